// *** shared/sie_regs.svh ***
// constants of the status indicator encoder: register offsets, fields,
// reset values and flash timing
// assumes a 50 MHz system clock and a word-wide register port
`ifndef SIE_REGS_SVH
`define SIE_REGS_SVH

`define SIE_CLK_HZ           50000000
`define SIE_TICK_MS          50
`define SIE_TICK_CYCLES      ((`SIE_CLK_HZ / 1000) * `SIE_TICK_MS)
`define SIE_PHASE_TICKS      20
`define SIE_SLOW_ON_TICKS    10
`define SIE_SHORT_ON_TICKS   2
`define SIE_CHO_SLOT_TICKS   4

`define SIE_ADDR_CTRL        4'h0
`define SIE_ADDR_STATUS      4'h4
`define SIE_CTRL_RESET       2'h0
`define SIE_CTRL_TEST_BIT    0
`define SIE_CTRL_DARK_BIT    1
`define SIE_ST_L1_LSB        0
`define SIE_ST_L2_LSB        4
`define SIE_ST_L3_LSB        8
`define SIE_ST_CH1_BIT       12
`define SIE_ST_CH2_BIT       13
`define SIE_ST_CHO_BIT       16
`define SIE_CHO_SLOTS_ONE    3'h2
`define SIE_CHO_SLOTS_TWO    3'h4

`endif

// *** shared/sie_pkg.sv ***
// types of the status indicator encoder
// assumes nothing beyond the constants header
package sie_pkg;
   typedef logic [31:0] sie_word_t;
   typedef logic [3:0]  sie_addr_t;

   typedef enum logic [2:0] {
      SIE_L1_RED       = 3'b000,
      SIE_L1_RED_SLOW  = 3'b001,
      SIE_L1_RED_FAST  = 3'b010,
      SIE_L1_GRN_SLOW  = 3'b011,
      SIE_L1_GRN       = 3'b100
   } sie_l1_mode_t;

   typedef enum logic [1:0] {
      SIE_L2_DARK      = 2'b00,
      SIE_L2_STEADY    = 2'b01,
      SIE_L2_FLASH     = 2'b10,
      SIE_L2_CHANGE    = 2'b11
   } sie_l2_mode_t;

   typedef enum logic [2:0] {
      SIE_L3_DARK      = 3'b000,
      SIE_L3_STEADY    = 3'b001,
      SIE_L3_SLOW      = 3'b010,
      SIE_L3_SHORT     = 3'b011,
      SIE_L3_FAST      = 3'b100
   } sie_l3_mode_t;
endpackage

// *** shared/sie_flash_if.sv ***
// flash timing bundle between the encoder and its flash generator
// assumes both ends run on the same system clock
interface sie_flash_if;
   logic restart;
   logic tick;
   logic slow;
   logic fast;
   logic short_on;

   modport gen  (input restart, output tick, output slow, output fast, output short_on);
   modport user (output restart, input tick, input slow, input fast, input short_on);
endinterface

// *** src/sie_flash_gen.sv ***
// flash generator: one tick prescaler and a phase counter per second
// assumes restart is a one-cycle request from the encoder
`include "sie_regs.svh"

module sie_flash_gen #(
   parameter int unsigned TICK_CYCLES = `SIE_TICK_CYCLES,
   parameter int unsigned PHASE_TICKS = `SIE_PHASE_TICKS
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   sie_flash_if.gen  fl
);
   import sie_pkg::*;

   localparam int unsigned PW = $clog2(TICK_CYCLES);
   localparam int unsigned CW = (PW < 1) ? 1 : PW;

   generate
      if (TICK_CYCLES < 2 || PHASE_TICKS != `SIE_PHASE_TICKS)
      begin : g_bad
         $error("sie_flash_gen: unsupported tick or phase count");
      end
   endgenerate

   logic [CW-1:0] pre_r;
   logic [4:0]    phase_r;
   logic          pre_end;

   assign pre_end = (pre_r == CW'(TICK_CYCLES - 1));

   ////////////////////////////////////////////////////////////////////////////
   // prescaler; restart realigns the phase so a new pattern starts lit
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         pre_r <= '0;
      else if (fl.restart || pre_end)
         pre_r <= '0;
      else
         pre_r <= pre_r + CW'(1);
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         phase_r <= 5'h0;
      else if (fl.restart)
         phase_r <= 5'h0;
      else if (pre_end)
         phase_r <= (phase_r == 5'(PHASE_TICKS - 1)) ? 5'h0 : phase_r + 5'h1;
   end

   assign fl.tick     = pre_end && !fl.restart;
   assign fl.slow     = (phase_r < 5'(`SIE_SLOW_ON_TICKS));
   assign fl.fast     = !phase_r[0];
   assign fl.short_on = (phase_r < 5'(`SIE_SHORT_ON_TICKS));

   ////////////////////////////////////////////////////////////////////////////
   restart_phase_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fl.restart |=> (phase_r == 5'h0) && (pre_r == '0) && fl.slow)
      else $error("flash phase not realigned by restart");

   phase_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (pre_end && !fl.restart && phase_r == 5'(PHASE_TICKS - 1)) |=> phase_r == 5'h0)
      else $error("flash phase did not wrap after one second");
endmodule

// *** src/sie_top.sv ***
// status indicator encoder: maps curtain status flags onto three lamps
// and decodes the supply polarity into the transmission channel
// assumes all status inputs are synchronous to MCLK_I and stable levels,
// except UPSTREAM_CHANGE_I which is a one-cycle event
//
// Strobed register access and the register offsets are this design's own decisions.
`include "sie_regs.svh"

// Summary of operation
// - first lamp flashes green at 1 Hz when safety outputs on, weak signal
// - first lamp flashes red 1 Hz on external error, 10 Hz on internal error
// - second lamp dark unless interlock blocked with field free and sensor enabled, or upstream circuit open or changing over
// - second lamp steady yellow when interlock blocked and ready to unlock
// - second lamp flashes yellow while the upstream safety circuit is open
// - second lamp flashes yellow once or twice on upstream circuit changeover
// - third lamp dark when no special function is active
// - third lamp steady blue once a blanking parameter is taught correctly
// - third lamp flashes blue at 1 Hz while muting is active
// - short blue flashes for teaching, muting restart required, or override
// - third lamp flashes blue at 10 Hz on a teaching error
// - pin A high, B low selects first channel; reversed selects second
module sie_top #(
   parameter int unsigned TICK_CYCLES = `SIE_TICK_CYCLES
) (
   input  wire logic              MCLK_I,
   input  wire logic              RESET_I,
   input  wire logic              SAFETY_OUTPUT_ON_I,
   input  wire logic              WEAK_SIGNAL_I,
   input  wire logic              EXT_ERROR_I,
   input  wire logic              INT_ERROR_I,
   input  wire logic              RESTART_INTERLOCK_ACTIVE_I,
   input  wire logic              RESTART_INTERLOCK_BLOCKED_I,
   input  wire logic              FIELD_FREE_I,
   input  wire logic              LINKED_SENSOR_OK_I,
   input  wire logic              UPSTREAM_OPEN_I,
   input  wire logic              UPSTREAM_CHANGE_I,
   input  wire logic              UPSTREAM_CHANGE_TWICE_I,
   input  wire logic              BLANK_TAUGHT_I,
   input  wire logic              MUTING_I,
   input  wire logic              TEACHING_I,
   input  wire logic              MUTING_RESTART_REQ_I,
   input  wire logic              MUTING_OVERRIDE_I,
   input  wire logic              TEACH_ERROR_I,
   input  wire logic              SUPPLY_PIN_A_I,
   input  wire logic              SUPPLY_PIN_B_I,
   input  wire sie_pkg::sie_addr_t REG_ADDR_I,
   input  wire sie_pkg::sie_word_t REG_WDATA_I,
   input  wire logic              REG_WR_I,
   input  wire logic              REG_RD_I,
   output logic                   LAMP1_RED_O,
   output logic                   LAMP1_GREEN_O,
   output logic                   LAMP2_YELLOW_O,
   output logic                   LAMP3_BLUE_O,
   output logic                   FIRST_TRANSMISSION_CHANNEL_O,
   output logic                   SECOND_TRANSMISSION_CHANNEL_O,
   output sie_pkg::sie_word_t     REG_RDATA_O
);
   import sie_pkg::*;

   generate
      if (TICK_CYCLES < 2)
      begin : g_bad
         $error("sie_top: tick count too small");
      end
   endgenerate

   sie_flash_if fl ();

   sie_l1_mode_t l1_mode_r;
   sie_l1_mode_t l1_mode_nxt;
   sie_l2_mode_t l2_mode_r;
   sie_l2_mode_t l2_mode_nxt;
   sie_l3_mode_t l3_mode_r;
   sie_l3_mode_t l3_mode_nxt;
   logic [1:0]   ctrl_r;
   logic [2:0]   cho_cnt_r;
   logic [1:0]   cho_tick_r;
   logic         cho_busy;
   logic         red_nxt;
   logic         green_nxt;
   logic         yellow_nxt;
   logic         blue_nxt;
   logic         lamp_test;
   logic         lamp_dark;

   sie_flash_gen #(
      .TICK_CYCLES (TICK_CYCLES),
      .PHASE_TICKS (`SIE_PHASE_TICKS)
   ) u_flash (
      .clk_i (MCLK_I),
      .rst_i (RESET_I),
      .fl    (fl.gen)
   );

   assign lamp_test = ctrl_r[`SIE_CTRL_TEST_BIT];
   assign lamp_dark = ctrl_r[`SIE_CTRL_DARK_BIT];
   assign cho_busy  = (cho_cnt_r != 3'h0);

   ////////////////////////////////////////////////////////////////////////////
   // mode selection; errors outrank everything on the first lamp
   always_comb
   begin
      if (INT_ERROR_I)
         l1_mode_nxt = SIE_L1_RED_FAST;
      else if (EXT_ERROR_I)
         l1_mode_nxt = SIE_L1_RED_SLOW;
      else if (!SAFETY_OUTPUT_ON_I)
         l1_mode_nxt = SIE_L1_RED;
      else if (WEAK_SIGNAL_I)
         l1_mode_nxt = SIE_L1_GRN_SLOW;
      else
         l1_mode_nxt = SIE_L1_GRN;
   end

   // a running changeover sequence is shown to its end before anything else
   always_comb
   begin
      if (cho_busy || UPSTREAM_CHANGE_I)
         l2_mode_nxt = SIE_L2_CHANGE;
      else if (UPSTREAM_OPEN_I)
         l2_mode_nxt = SIE_L2_FLASH;
      else if (RESTART_INTERLOCK_ACTIVE_I && RESTART_INTERLOCK_BLOCKED_I
               && FIELD_FREE_I && LINKED_SENSOR_OK_I)
         l2_mode_nxt = SIE_L2_STEADY;
      else
         l2_mode_nxt = SIE_L2_DARK;
   end

   always_comb
   begin
      if (TEACH_ERROR_I)
         l3_mode_nxt = SIE_L3_FAST;
      else if (TEACHING_I || MUTING_RESTART_REQ_I || MUTING_OVERRIDE_I)
         l3_mode_nxt = SIE_L3_SHORT;
      else if (MUTING_I)
         l3_mode_nxt = SIE_L3_SLOW;
      else if (BLANK_TAUGHT_I)
         l3_mode_nxt = SIE_L3_STEADY;
      else
         l3_mode_nxt = SIE_L3_DARK;
   end

   // any change of a displayed state starts the flash pattern afresh
   assign fl.restart = (l1_mode_nxt != l1_mode_r) || (l2_mode_nxt != l2_mode_r)
                       || (l3_mode_nxt != l3_mode_r);

   always_ff @(posedge MCLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         l1_mode_r <= SIE_L1_RED;
         l2_mode_r <= SIE_L2_DARK;
         l3_mode_r <= SIE_L3_DARK;
      end
      else
      begin
         l1_mode_r <= l1_mode_nxt;
         l2_mode_r <= l2_mode_nxt;
         l3_mode_r <= l3_mode_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // changeover sequence: two slots per flash, lit on even counts;
   // a new event during a sequence restarts it rather than queueing
   always_ff @(posedge MCLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         cho_cnt_r  <= 3'h0;
         cho_tick_r <= 2'h0;
      end
      else if (UPSTREAM_CHANGE_I)
      begin
         cho_cnt_r  <= UPSTREAM_CHANGE_TWICE_I ? `SIE_CHO_SLOTS_TWO : `SIE_CHO_SLOTS_ONE;
         cho_tick_r <= 2'h0;
      end
      else if (cho_busy && fl.tick)
      begin
         if (cho_tick_r == 2'(`SIE_CHO_SLOT_TICKS - 1))
         begin
            cho_tick_r <= 2'h0;
            cho_cnt_r  <= cho_cnt_r - 3'h1;
         end
         else
            cho_tick_r <= cho_tick_r + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // lamp drive; dark control outranks lamp test
   always_comb
   begin
      red_nxt   = 1'b0;
      green_nxt = 1'b0;
      unique case (l1_mode_r)
         SIE_L1_RED:      red_nxt   = 1'b1;
         SIE_L1_RED_SLOW: red_nxt   = fl.slow;
         SIE_L1_RED_FAST: red_nxt   = fl.fast;
         SIE_L1_GRN_SLOW: green_nxt = fl.slow;
         SIE_L1_GRN:      green_nxt = 1'b1;
         default:         red_nxt   = 1'b1;
      endcase
   end

   always_comb
   begin
      yellow_nxt = 1'b0;
      unique case (l2_mode_r)
         SIE_L2_DARK:   yellow_nxt = 1'b0;
         SIE_L2_STEADY: yellow_nxt = 1'b1;
         SIE_L2_FLASH:  yellow_nxt = fl.slow;
         SIE_L2_CHANGE: yellow_nxt = cho_busy && !cho_cnt_r[0];
      endcase
   end

   always_comb
   begin
      blue_nxt = 1'b0;
      unique case (l3_mode_r)
         SIE_L3_DARK:   blue_nxt = 1'b0;
         SIE_L3_STEADY: blue_nxt = 1'b1;
         SIE_L3_SLOW:   blue_nxt = fl.slow;
         SIE_L3_SHORT:  blue_nxt = fl.short_on;
         SIE_L3_FAST:   blue_nxt = fl.fast;
         default:       blue_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge MCLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         LAMP1_RED_O    <= 1'b0;
         LAMP1_GREEN_O  <= 1'b0;
         LAMP2_YELLOW_O <= 1'b0;
         LAMP3_BLUE_O   <= 1'b0;
      end
      else if (lamp_dark)
      begin
         LAMP1_RED_O    <= 1'b0;
         LAMP1_GREEN_O  <= 1'b0;
         LAMP2_YELLOW_O <= 1'b0;
         LAMP3_BLUE_O   <= 1'b0;
      end
      else if (lamp_test)
      begin
         LAMP1_RED_O    <= 1'b1;
         LAMP1_GREEN_O  <= 1'b1;
         LAMP2_YELLOW_O <= 1'b1;
         LAMP3_BLUE_O   <= 1'b1;
      end
      else
      begin
         LAMP1_RED_O    <= red_nxt;
         LAMP1_GREEN_O  <= green_nxt;
         LAMP2_YELLOW_O <= yellow_nxt;
         LAMP3_BLUE_O   <= blue_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // channel decode; equal polarity on both pins selects neither channel
   always_ff @(posedge MCLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         FIRST_TRANSMISSION_CHANNEL_O  <= 1'b0;
         SECOND_TRANSMISSION_CHANNEL_O <= 1'b0;
      end
      else
      begin
         FIRST_TRANSMISSION_CHANNEL_O  <= SUPPLY_PIN_A_I && !SUPPLY_PIN_B_I;
         SECOND_TRANSMISSION_CHANNEL_O <= !SUPPLY_PIN_A_I && SUPPLY_PIN_B_I;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register port
   always_ff @(posedge MCLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         ctrl_r <= `SIE_CTRL_RESET;
      else if (REG_WR_I && REG_ADDR_I == `SIE_ADDR_CTRL)
         ctrl_r <= REG_WDATA_I[1:0];
   end

   always_ff @(posedge MCLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         REG_RDATA_O <= 32'h0000_0000;
      else
      begin
         REG_RDATA_O <= 32'h0000_0000;
         if (REG_RD_I && REG_ADDR_I == `SIE_ADDR_CTRL)
            REG_RDATA_O[1:0] <= ctrl_r;
         else if (REG_RD_I && REG_ADDR_I == `SIE_ADDR_STATUS)
         begin
            REG_RDATA_O[`SIE_ST_L1_LSB +: 3] <= l1_mode_r;
            REG_RDATA_O[`SIE_ST_L2_LSB +: 2] <= l2_mode_r;
            REG_RDATA_O[`SIE_ST_L3_LSB +: 3] <= l3_mode_r;
            REG_RDATA_O[`SIE_ST_CH1_BIT]     <= FIRST_TRANSMISSION_CHANNEL_O;
            REG_RDATA_O[`SIE_ST_CH2_BIT]     <= SECOND_TRANSMISSION_CHANNEL_O;
            REG_RDATA_O[`SIE_ST_CHO_BIT]     <= cho_busy;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   green_weak_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
      (SAFETY_OUTPUT_ON_I && WEAK_SIGNAL_I && !INT_ERROR_I && !EXT_ERROR_I)
      |=> l1_mode_r == SIE_L1_GRN_SLOW)
      else $error("weak signal not shown as slow green");

   red_error_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
      (l1_mode_r == SIE_L1_RED_FAST && ctrl_r == 2'h0)
      |=> LAMP1_RED_O == $past(fl.fast) && !LAMP1_GREEN_O)
      else $error("internal error not shown as fast red");

   lamp2_dark_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
      (!RESTART_INTERLOCK_ACTIVE_I && !UPSTREAM_OPEN_I && !UPSTREAM_CHANGE_I && !cho_busy)
      |=> l2_mode_r == SIE_L2_DARK)
      else $error("second lamp not dark with interlock off");

   yellow_steady_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
      (l2_mode_r == SIE_L2_STEADY && ctrl_r == 2'h0) |=> LAMP2_YELLOW_O)
      else $error("ready interlock not shown steady yellow");

   upstream_flash_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
      (UPSTREAM_OPEN_I && !UPSTREAM_CHANGE_I && !cho_busy) |=> l2_mode_r == SIE_L2_FLASH)
      else $error("open upstream circuit not shown flashing");

   changeover_load_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
      UPSTREAM_CHANGE_I |=> cho_cnt_r == ($past(UPSTREAM_CHANGE_TWICE_I) ? 3'h4 : 3'h2))
      else $error("changeover flash count wrong");

   lamp3_dark_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
      (l3_mode_r == SIE_L3_DARK && !lamp_test) |=> !LAMP3_BLUE_O)
      else $error("third lamp lit with no special function");

   blue_steady_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
      (BLANK_TAUGHT_I && !MUTING_I && !TEACHING_I && !MUTING_RESTART_REQ_I
       && !MUTING_OVERRIDE_I && !TEACH_ERROR_I) |=> ##1 (LAMP3_BLUE_O || $past(lamp_dark)))
      else $error("taught blanking not shown steady blue");

   teach_fast_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
      (l3_mode_r == SIE_L3_FAST && ctrl_r == 2'h0) |=> LAMP3_BLUE_O == $past(fl.fast))
      else $error("teach error not shown as fast blue");

   channel_sel_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
      1'b1 |=> FIRST_TRANSMISSION_CHANNEL_O == ($past(SUPPLY_PIN_A_I) && !$past(SUPPLY_PIN_B_I))
      && SECOND_TRANSMISSION_CHANNEL_O == (!$past(SUPPLY_PIN_A_I) && $past(SUPPLY_PIN_B_I)))
      else $error("transmission channel decode wrong");

   red_off_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
      (!SAFETY_OUTPUT_ON_I && !INT_ERROR_I && !EXT_ERROR_I)
      |=> ##1 (($past(ctrl_r) != 2'h0) || (LAMP1_RED_O && !LAMP1_GREEN_O)))
      else $error("outputs off not shown steady red");

   mode_restart_a: assert property (@(posedge MCLK_I) disable iff (RESET_I)
      ($changed(l1_mode_r) || $changed(l2_mode_r) || $changed(l3_mode_r)) |-> $past(fl.restart))
      else $error("mode change without flash restart");

   weak_seen_c:  cover property (@(posedge MCLK_I) disable iff (RESET_I)
      l1_mode_r == SIE_L1_GRN_SLOW ##1 LAMP1_GREEN_O);
   cho_two_c:    cover property (@(posedge MCLK_I) disable iff (RESET_I)
      (UPSTREAM_CHANGE_I && UPSTREAM_CHANGE_TWICE_I) ##1 cho_cnt_r == 3'h4);
   muting_c:     cover property (@(posedge MCLK_I) disable iff (RESET_I)
      l3_mode_r == SIE_L3_SLOW ##1 LAMP3_BLUE_O);
   channel_two_c: cover property (@(posedge MCLK_I) disable iff (RESET_I)
      SECOND_TRANSMISSION_CHANNEL_O);
endmodule

// *** tb/sie_lamp_observer.sv ***
// lamp observer: stands in for the operator watching the indicator lamps
// assumes the lamp outputs are registered on the same clock
module sie_lamp_observer (
   input  wire logic             clk_i,
   input  wire logic             clr_i,
   input  wire logic [3:0]       lamp_i,
   output logic      [3:0][7:0]  lit_o,
   output logic      [3:0][7:0]  rise_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0] prev_r;

   // only levels after the clear are counted, so a window spans whole flash periods
   always_ff @(posedge clk_i)
   begin
      prev_r <= lamp_i;
      for (int i = 0; i < 4; i++)
      begin
         if (clr_i)
         begin
            lit_o[i]  <= 8'h00;
            rise_o[i] <= 8'h00;
         end
         else
         begin
            lit_o[i]  <= lit_o[i] + 8'(lamp_i[i]);
            rise_o[i] <= rise_o[i] + 8'(lamp_i[i] & ~prev_r[i]);
         end
      end
   end
endmodule

// *** tb/status_indicator_encoder_tb.sv ***
// testbench of the status indicator encoder: flag patterns in, lamp counts out
// assumes TICK_CYCLES of 4, so one flash period is 80 clocks
`include "sie_regs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
   $display("[ERR] %0t mismatch got %h exp %h", $time, (a), (b)); end end

module status_indicator_encoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sie_pkg::*;

   logic            clk = 1'b0;
   logic            rst = 1'b1;
   logic [18:0]     st = 19'h0_0000;
   logic            clr = 1'b0;
   sie_addr_t       reg_addr = 4'h0;
   sie_word_t       reg_wdata = 32'h0000_0000;
   logic            reg_wr = 1'b0;
   logic            reg_rd = 1'b0;
   sie_word_t       rdata;
   sie_word_t       d;
   logic            red, green, yellow, blue, ch1, ch2;
   logic [3:0][7:0] lit, rise;
   int              errors = 0;
   int              tests_run = 0;

   always #10 clk = ~clk;

   sie_top #(.TICK_CYCLES(4)) i_dut (
      .MCLK_I(clk), .RESET_I(rst),
      .SAFETY_OUTPUT_ON_I(st[0]), .WEAK_SIGNAL_I(st[1]),
      .EXT_ERROR_I(st[2]), .INT_ERROR_I(st[3]),
      .RESTART_INTERLOCK_ACTIVE_I(st[4]), .RESTART_INTERLOCK_BLOCKED_I(st[5]),
      .FIELD_FREE_I(st[6]), .LINKED_SENSOR_OK_I(st[7]),
      .UPSTREAM_OPEN_I(st[8]), .UPSTREAM_CHANGE_I(st[9]),
      .UPSTREAM_CHANGE_TWICE_I(st[10]), .BLANK_TAUGHT_I(st[11]),
      .MUTING_I(st[12]), .TEACHING_I(st[13]), .MUTING_RESTART_REQ_I(st[14]),
      .MUTING_OVERRIDE_I(st[15]), .TEACH_ERROR_I(st[16]),
      .SUPPLY_PIN_A_I(st[17]), .SUPPLY_PIN_B_I(st[18]),
      .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata),
      .REG_WR_I(reg_wr), .REG_RD_I(reg_rd),
      .LAMP1_RED_O(red), .LAMP1_GREEN_O(green), .LAMP2_YELLOW_O(yellow),
      .LAMP3_BLUE_O(blue), .FIRST_TRANSMISSION_CHANNEL_O(ch1),
      .SECOND_TRANSMISSION_CHANNEL_O(ch2), .REG_RDATA_O(rdata)
   );

   sie_lamp_observer i_obs (
      .clk_i(clk), .clr_i(clr), .lamp_i({blue, yellow, green, red}),
      .lit_o(lit), .rise_o(rise)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic wr(input sie_addr_t a, input sie_word_t v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // read data is looked at only in the cycle after the strobe, then must drop
   task automatic rd(input sie_addr_t a, output sie_word_t v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      v = rdata;
      @(negedge clk);
      `CHK(rdata, 32'h0000_0000)
   endtask

   // lit and rise pack blue, yellow, green, red a byte each, over 80 clocks
   task automatic run_case(input logic [18:0] v, input int settle,
                           input logic [31:0] elit, input logic [31:0] erise);
      @(posedge clk);
      st <= v;
      @(posedge clk);
      st[9] <= 1'b0;
      repeat (settle) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (80) @(posedge clk);
      @(negedge clk);
      `CHK(lit, elit)
      `CHK(rise, erise)
      `CHK({ch1, ch2}, {v[17] & ~v[18], ~v[17] & v[18]})
   endtask

   // a lamp1 mode change during a dark blue phase must relight blue at once
   task automatic restart_check();
      int n;
      n = 0;
      while (blue !== 1'b0 && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      `CHK(n < 100, 1'b1)
      if (n >= 100)
         end_of_test();
      else
      begin
         @(posedge clk);
         st[1] <= 1'b1;
         repeat (3) @(posedge clk);
         @(negedge clk);
         `CHK(blue, 1'b1)
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      end_of_test();
   end

   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      run_case(19'h0_0000, 4, 32'h0000_0050, 32'h0000_0000);
      run_case(19'h2_0001, 4, 32'h0000_5000, 32'h0000_0000);
      run_case(19'h4_0003, 4, 32'h0000_2800, 32'h0000_0100);
      run_case(19'h0_0004, 4, 32'h0000_0028, 32'h0000_0001);
      run_case(19'h6_000C, 4, 32'h0000_0028, 32'h0000_000A);
      run_case(19'h2_00F1, 4, 32'h0050_5000, 32'h0000_0000);
      run_case(19'h2_0101, 4, 32'h0028_5000, 32'h0001_0000);
      run_case(19'h2_00B1, 4, 32'h0000_5000, 32'h0000_0000);
      run_case(19'h2_00D1, 4, 32'h0000_5000, 32'h0000_0000);
      run_case(19'h2_00E1, 4, 32'h0000_5000, 32'h0000_0000);
      run_case(19'h2_0201, 0, 32'h0010_5000, 32'h0001_0000);
      run_case(19'h2_0601, 0, 32'h0020_5000, 32'h0002_0000);
      run_case(19'h2_0801, 4, 32'h5000_5000, 32'h0000_0000);
      run_case(19'h2_1001, 4, 32'h2800_5000, 32'h0100_0000);
      restart_check();
      run_case(19'h2_2001, 4, 32'h0800_5000, 32'h0100_0000);
      run_case(19'h2_4001, 4, 32'h0800_5000, 32'h0100_0000);
      run_case(19'h2_8001, 4, 32'h0800_5000, 32'h0100_0000);
      run_case(19'h3_2001, 4, 32'h2800_5000, 32'h0A00_0000);
      wr(`SIE_ADDR_CTRL, 32'h0000_0001);
      repeat (3) @(posedge clk);
      @(negedge clk);
      `CHK({blue, yellow, green, red}, 4'hF)
      wr(`SIE_ADDR_CTRL, 32'h0000_0003);
      rd(`SIE_ADDR_CTRL, d);
      `CHK(d, 32'h0000_0003)
      `CHK({blue, yellow, green, red}, 4'h0)
      wr(`SIE_ADDR_CTRL, 32'h0000_0000);
      wr(`SIE_ADDR_STATUS, 32'hFFFF_FFFF);
      @(posedge clk);
      st <= 19'h2_0001;
      repeat (4) @(posedge clk);
      rd(`SIE_ADDR_STATUS, d);
      `CHK(d, 32'(SIE_L1_GRN) | (32'h0000_0001 << `SIE_ST_CH1_BIT))
      rd(4'h8, d);
      `CHK(d, 32'h0000_0000)
      end_of_test();
   end
endmodule
